// ===== pkg/dual_timer_map.svh
// offsets, bit positions, reset values and counts of the dual timer block
// assumes: included by bare name from the package and the design file
`ifndef DUAL_TIMER_MAP_SVH
`define DUAL_TIMER_MAP_SVH

// register byte offsets on the apb slave
`define DT_OFS_MODE 8'h00
`define DT_OFS_CTRL 8'h04
`define DT_OFS_DIV 8'h08
`define DT_OFS_T0L 8'h0c
`define DT_OFS_T0H 8'h10
`define DT_OFS_T1L 8'h14
`define DT_OFS_T1H 8'h18
`define DT_OFS_STAT 8'h1c
`define DT_OFS_MASK 8'h20

// mode register field positions
`define DT_M0_LO 0
`define DT_M0_HI 1
`define DT_CT0 2
`define DT_M1_LO 4
`define DT_M1_HI 5
`define DT_CT1 6
// writable bits of the mode register, bits 7 and 3 reserved
`define DT_MODE_WMASK 8'h77

// control, divider, status and mask bit positions
`define DT_RUN0 0
`define DT_RUN1 1
`define DT_FD0 0
`define DT_FD1 1
`define DT_OVF0 0
`define DT_OVF1 1

// reset values
`define DT_RST_BYTE 8'h00
`define DT_RST_2BIT 2'h0

// slow timer tick is the system clock divided by this ratio
`define DT_PRESCALE 12
`define DT_PRE_W 4

`endif

// ===== pkg/dual_timer_pkg.sv
// types shared by the dual timer block and its bench
// assumes: the map header sits beside it on the include path
package dual_timer_pkg;
`include "dual_timer_map.svh"

    // two-bit mode select, in field order 00, 01, 10, 11
    typedef enum logic [1:0] {
        MODE_13BIT,
        MODE_16BIT,
        MODE_RELOAD8,
        MODE_SPLIT
    } mode_e;

    // one step of a counter pair
    typedef struct packed {
        logic ovf;
        logic [7:0] hi;
        logic [7:0] lo;
    } step_s;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    // apb answer from this slave
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_s;

endpackage

// ===== test/edge_source.sv
// far-side model: an event source that pulses the two counter input pins
// assumes: driven from the bench on the system clock; pins idle high as with a pull-up
`timescale 1ns/1ps
`default_nettype none

module edge_source (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // burst request
    input wire logic i_go,
    input wire logic i_sel,
    input wire logic [7:0] i_count,
    input wire logic [3:0] i_half,
    // pins and status
    output logic [1:0] o_pin,
    output logic o_busy
);
    logic [7:0] left;
    logic [3:0] tick;
    logic lvl;
    logic sel;

    ////////////////////////////////////////////////////////////////////////////////
    // each pulse is high then low for i_half cycles; wide halves model a slow source
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            left <= 8'h00;
            tick <= 4'h0;
            lvl <= 1'b1;
            sel <= 1'b0;
        end else if (i_go && left == 8'h00) begin
            left <= i_count;
            sel <= i_sel;
            tick <= i_half;
            lvl <= 1'b1;
        end else if (left != 8'h00) begin
            if (tick > 4'h1) begin
                tick <= tick - 4'h1;
            end else begin
                tick <= i_half;
                lvl <= ~lvl;
                if (!lvl) begin
                    left <= left - 8'h01;
                end
            end
        end
    end

    // the idle pin rests high, so no falling edge appears outside a burst
    assign o_pin = sel ? {lvl, 1'b1} : {1'b1, lvl};
    assign o_busy = (left != 8'h00);
endmodule
`default_nettype wire

// ===== test/test_dual_legacy_timer_counter.sv
// self-checking bench of the dual timer block: apb master, pin source, scenarios
// assumes: package and map header compiled first, edge_source model alongside
`timescale 1ns/1ps
`default_nettype none
`include "dual_timer_map.svh"
`define TB_CHECK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin errors++; $display("mismatch %s expected %h seen %h", what, exp, got); end end

module test_dual_legacy_timer_counter;
    import dual_timer_pkg::*;
    logic i_clock;
    logic i_nrst;
    apb_req_s apb;
    apb_rsp_s rsp;
    logic [1:0] pins;
    logic irq;
    logic go;
    logic go_sel;
    logic [7:0] go_count;
    logic [3:0] go_half;
    logic busy;
    logic [31:0] rdata;
    logic rerr;
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;

    dual_legacy_timer_counter DUT (.i_clock(i_clock), .i_nrst(i_nrst), .i_apb(apb),
        .o_apb(rsp), .i_first_counter_input_pin(pins[0]),
        .i_second_counter_input_pin(pins[1]), .o_irq(irq));
    edge_source src (.i_clock(i_clock), .i_nrst(i_nrst), .i_go(go), .i_sel(go_sel),
        .i_count(go_count), .i_half(go_half), .o_pin(pins), .o_busy(busy));

    ////////////////////////////////////////////////////////////////////////////////
    // clock and hang guard; the run needs a few thousand cycles at most
    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // bus and pin helpers
    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_clock);
    endtask

    // request held until pready is seen high, then released at that same edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        @(posedge i_clock);
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h000000, d}};
        @(posedge i_clock);
        apb.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge i_clock);
            k++;
        end while (rsp.pready !== 1'b1);
        rdata = rsp.prdata;
        rerr = rsp.pslverr;
        apb <= '0;
        // setup, one plain access cycle, then pready; a hang is left to the guard
        `TB_CHECK("apb wait cycles", 2, k)
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e, input string what);
        xfer(1'b0, a, 8'h00);
        `TB_CHECK(what, {24'h000000, e}, rdata)
    endtask

    // one burst of falling edges, then time for the synchroniser to settle
    task automatic send(input logic s, input logic [7:0] n, input logic [3:0] h);
        int k;
        @(posedge i_clock);
        go <= 1'b1;
        go_sel <= s;
        go_count <= n;
        go_half <= h;
        @(posedge i_clock);
        go <= 1'b0;
        k = 0;
        do begin
            @(posedge i_clock);
            k++;
        end while (busy && k < 600);
        wait_clk(8);
    endtask

    task automatic finish_test(input string s);
        $display("finished %s mismatches so far %0d", s, errors);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_regs();
        logic [7:0] ofs [9];
        ofs = '{`DT_OFS_MODE, `DT_OFS_CTRL, `DT_OFS_DIV, `DT_OFS_T0L, `DT_OFS_T0H,
            `DT_OFS_T1L, `DT_OFS_T1H, `DT_OFS_STAT, `DT_OFS_MASK};
        foreach (ofs[i]) chk_rd(ofs[i], `DT_RST_BYTE, "reset value");
        xfer(1'b1, 8'h24, 8'h5a);
        `TB_CHECK("unmapped write error", 1'b1, rerr)
        chk_rd(8'h24, 8'h00, "unmapped read");
        `TB_CHECK("unmapped read error", 1'b1, rerr)
        wr(`DT_OFS_MODE, 8'hff);
        chk_rd(`DT_OFS_MODE, `DT_MODE_WMASK, "mode fields");
        `TB_CHECK("mapped error", 1'b0, rerr)
        wr(`DT_OFS_MODE, 8'h00);
        finish_test("registers");
    endtask

    // 16-bit then 13-bit wrap on one timer, fast clock, interrupt of the timer under test
    task automatic t_wide(input int t);
        logic [7:0] lo;
        logic [7:0] hi;
        logic [7:0] b;
        lo = t ? `DT_OFS_T1L : `DT_OFS_T0L;
        hi = t ? `DT_OFS_T1H : `DT_OFS_T0H;
        b = t ? 8'h02 : 8'h01;
        wr(`DT_OFS_DIV, b);
        wr(`DT_OFS_MASK, b);
        for (int m = 1; m >= 0; m--) begin
            wr(`DT_OFS_MODE, m[7:0] << (t ? 4 : 0));
            wr(hi, 8'hff);
            wr(lo, m ? 8'hfc : 8'h1c);
            wr(`DT_OFS_CTRL, b);
            wait_clk(10);
            wr(`DT_OFS_CTRL, 8'h00);
            chk_rd(hi, 8'h00, "wrapped high byte");
            `TB_CHECK("irq level", 1'b1, irq)
            chk_rd(`DT_OFS_STAT, b, "overflow flag");
            chk_rd(`DT_OFS_STAT, 8'h00, "status after read");
            `TB_CHECK("irq after clear", 1'b0, irq)
        end
        finish_test("wide modes");
    endtask

    task automatic t_reload(input int t);
        logic [7:0] b;
        b = t ? 8'h02 : 8'h01;
        wr(`DT_OFS_MODE, t ? 8'h20 : 8'h02);
        wr(`DT_OFS_DIV, b);
        wr(t ? `DT_OFS_T1H : `DT_OFS_T0H, 8'h80);
        wr(t ? `DT_OFS_T1L : `DT_OFS_T0L, 8'hfe);
        wr(`DT_OFS_CTRL, b);
        wait_clk(20);
        wr(`DT_OFS_CTRL, 8'h00);
        chk_rd(t ? `DT_OFS_T1H : `DT_OFS_T0H, 8'h80, "reload value kept");
        xfer(1'b0, t ? `DT_OFS_T1L : `DT_OFS_T0L, 8'h00);
        `TB_CHECK("reloaded low byte", 1'b1, rdata[7])
        chk_rd(`DT_OFS_STAT, b, "reload overflow");
        finish_test("reload");
    endtask

    task automatic t_halt();
        wr(`DT_OFS_MODE, 8'h30);
        wr(`DT_OFS_T1L, 8'h00);
        wr(`DT_OFS_DIV, 8'h02);
        wr(`DT_OFS_CTRL, 8'h02);
        wait_clk(20);
        wr(`DT_OFS_CTRL, 8'h00);
        chk_rd(`DT_OFS_T1L, 8'h00, "halted low byte");
        chk_rd(`DT_OFS_STAT, 8'h00, "halted status");
        finish_test("halt");
    endtask

    // both timers on the /12 tick; run and stop land 124 edges apart, so 10 or 11 ticks
    task automatic t_prescale();
        int e;
        e = 124 / `DT_PRESCALE;
        wr(`DT_OFS_MODE, 8'h11);
        wr(`DT_OFS_DIV, 8'h00);
        wr(`DT_OFS_T0H, 8'h00);
        wr(`DT_OFS_T0L, 8'h00);
        wr(`DT_OFS_T1H, 8'h00);
        wr(`DT_OFS_T1L, 8'h00);
        wr(`DT_OFS_CTRL, 8'h03);
        wait_clk(120);
        wr(`DT_OFS_CTRL, 8'h00);
        xfer(1'b0, `DT_OFS_T0L, 8'h00);
        `TB_CHECK("divided count", 1'b1, (rdata == e || rdata == e + 1))
        xfer(1'b0, `DT_OFS_T1L, 8'h00);
        `TB_CHECK("second divided count", 1'b1, (rdata == e || rdata == e + 1))
        finish_test("prescale");
    endtask

    task automatic t_pins();
        wr(`DT_OFS_MODE, 8'h55);
        wr(`DT_OFS_T0L, 8'h00);
        wr(`DT_OFS_T1L, 8'h00);
        send(1'b0, 8'd3, 4'd3);
        chk_rd(`DT_OFS_T0L, 8'h00, "stopped counter");
        wr(`DT_OFS_CTRL, 8'h03);
        send(1'b0, 8'd5, 4'd3);
        send(1'b1, 8'd4, 4'd8);
        wr(`DT_OFS_CTRL, 8'h00);
        chk_rd(`DT_OFS_T0L, 8'h05, "first pin edges");
        chk_rd(`DT_OFS_T1L, 8'h04, "second pin edges");
        wr(`DT_OFS_CTRL, 8'h01);
        send(1'b0, 8'd1, 4'd3);
        wr(`DT_OFS_CTRL, 8'h00);
        chk_rd(`DT_OFS_T0L, 8'h06, "resumed count");
        finish_test("pins");
    endtask

    task automatic t_split();
        wr(`DT_OFS_MODE, 8'h07);
        wr(`DT_OFS_DIV, 8'h03);
        wr(`DT_OFS_T0H, 8'hf0);
        wr(`DT_OFS_T0L, 8'h00);
        wr(`DT_OFS_T1L, 8'h00);
        xfer(1'b0, `DT_OFS_STAT, 8'h00);
        wr(`DT_OFS_MASK, 8'h02);
        wr(`DT_OFS_CTRL, 8'h03);
        send(1'b0, 8'd2, 4'd3);
        wr(`DT_OFS_CTRL, 8'h00);
        `TB_CHECK("split irq", 1'b1, irq)
        chk_rd(`DT_OFS_T0L, 8'h02, "split low byte");
        chk_rd(`DT_OFS_STAT, 8'h02, "split high overflow");
        chk_rd(`DT_OFS_T1L, 8'h00, "second counter held");
        finish_test("split");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        i_nrst = 1'b0;
        apb = '0;
        go = 1'b0;
        go_sel = 1'b0;
        go_count = 8'h00;
        go_half = 4'h3;
        repeat (3) @(posedge i_clock);
        i_nrst <= 1'b1;
        t_regs();
        t_wide(0);
        t_wide(1);
        t_reload(0);
        t_reload(1);
        t_halt();
        t_prescale();
        t_pins();
        t_split();
        report_and_stop();
    end
endmodule
`default_nettype wire

// ===== verilog/dual_legacy_timer_counter.sv
// dual up-counting timer/counter with apb register access
// assumes: one system clock, apb master on the same clock, counter
// input pins asynchronous to the clock
//
// Function
// RULE1: first timer has four modes via field
// RULE2: codes 13bit, 16bit, reload8, split or halt
// RULE3: 13bit uses high byte plus low 5 bits
// RULE4: first overflow sets flag, masked interrupt
// RULE5: second 13bit overflow sets its flag
// RULE6: select 1 counts falling pin edges
// RULE7: select 0 counts divided system clock
// RULE8: divider bit 0 is /12, 1 undivided
// RULE9: run bit gates counting, value kept
// RULE10: software loads start value before running
// RULE11: 16bit uses both bytes, same behaviour
// RULE12: reload mode counts low, high holds reload
// RULE13: low wrap sets flag, copies high byte
// RULE14: second timer reload mode behaves identically
// RULE15: split low byte uses first timer controls
// RULE16: split high byte: divided clock, second controls
// RULE17: split mode stops the second counter
// RULE18: second timer has no split mode
// RULE19: pins synchronised, one count per edge
`timescale 1ns/1ps
`default_nettype none
`include "dual_timer_map.svh"

module dual_legacy_timer_counter (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // apb slave
    input wire dual_timer_pkg::apb_req_s i_apb,
    output var dual_timer_pkg::apb_rsp_s o_apb,
    // external counter inputs
    input wire logic i_first_counter_input_pin,
    input wire logic i_second_counter_input_pin,
    // interrupt
    output logic o_irq
);
    import dual_timer_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // storage

    logic [7:0] timer_mode_register;
    logic [1:0] timer_control_register;
    logic [1:0] timer_divider_register;
    logic [7:0] first_timer_low_byte;
    logic [7:0] first_timer_high_byte;
    logic [7:0] second_timer_low_byte;
    logic [7:0] second_timer_high_byte;
    logic [1:0] timer_status;
    logic [1:0] timer_mask;
    logic [`DT_PRE_W-1:0] pre_cnt;
    logic [31:0] rd_data;
    logic rd_err;
    logic ready;
    logic irq;

    ////////////////////////////////////////////////////////////////////
    // helpers

    // true for any offset that holds a register
    function automatic logic known_addr(input logic [7:0] a);
        case (a)
            `DT_OFS_MODE, `DT_OFS_CTRL, `DT_OFS_DIV, `DT_OFS_T0L,
            `DT_OFS_T0H, `DT_OFS_T1L, `DT_OFS_T1H, `DT_OFS_STAT,
            `DT_OFS_MASK: known_addr = 1'b1;
            default: known_addr = 1'b0;
        endcase
    endfunction

    // one increment of a counter pair in the given mode
    function automatic step_s step(input mode_e m, input logic [7:0] hi,
                                   input logic [7:0] lo);
        logic [13:0] s13;
        logic [16:0] s16;
        logic [8:0] s8;
        s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
        s16 = {1'b0, hi, lo} + 17'h00001;
        s8 = {1'b0, lo} + 9'h001;
        case (m)
            MODE_13BIT: begin
                // upper three low bits are not part of the count
                step = '{ovf: s13[13], hi: s13[12:5], lo: {lo[7:5], s13[4:0]}}; // RULE3
            end
            MODE_16BIT: begin
                step = '{ovf: s16[16], hi: s16[15:8], lo: s16[7:0]}; // RULE11
            end
            MODE_RELOAD8: begin
                // on wrap the low byte takes the reload value
                step = '{ovf: s8[8], hi: hi, lo: s8[8] ? hi : s8[7:0]}; // RULE12 RULE13
            end
            default: begin
                // split: low byte alone, high byte counted elsewhere
                step = '{ovf: s8[8], hi: hi, lo: s8[7:0]}; // RULE15
            end
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // apb decode

    logic bus_setup;
    logic bus_done;
    logic wr_now;
    logic rd_stat;
    assign bus_setup = i_apb.psel & i_apb.penable & ~ready;
    assign bus_done = i_apb.psel & i_apb.penable & ready;
    assign wr_now = bus_done & i_apb.pwrite & known_addr(i_apb.paddr);
    assign rd_stat = bus_done & ~i_apb.pwrite & (i_apb.paddr == `DT_OFS_STAT);

    // write strobe for one offset
    function automatic logic wr_at(input logic [7:0] ofs);
        wr_at = wr_now && (i_apb.paddr == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers and falling edge detect

    logic [1:0] pin_in;
    logic [1:0] pin_fall;
    assign pin_in = {i_second_counter_input_pin, i_first_counter_input_pin};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_pin
            logic s1;
            logic s2;
            logic s3;
            logic level;
            // three stages; a level counts once the last two agree
            always_ff @(posedge i_clock or negedge i_nrst) begin
                if (!i_nrst) begin
                    s1 <= 1'b1;
                    s2 <= 1'b1;
                    s3 <= 1'b1;
                    level <= 1'b1;
                end else begin
                    s1 <= pin_in[g];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3) begin
                        level <= s3; // RULE19
                    end
                end
            end
            // a high to low settle gives exactly one pulse
            assign pin_fall[g] = level & ~s2 & ~s3; // RULE19
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // prescaler: free running, so a timer tick is never longer than 12

    logic pre_tick;
    assign pre_tick = (pre_cnt == `DT_PRE_W'(`DT_PRESCALE - 1));

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            pre_cnt <= '0;
        end else begin
            pre_cnt <= pre_tick ? '0 : pre_cnt + `DT_PRE_W'(1); // RULE8
        end
    end

    ////////////////////////////////////////////////////////////////////
    // count sources and enables

    mode_e m0;
    mode_e m1;
    logic split;
    logic [1:0] base;
    logic [1:0] src;
    logic inc0;
    logic inc0h;
    logic inc1;
    step_s s0;
    step_s s1;
    logic ovf0;
    logic ovf0h;
    logic ovf1;
    logic [1:0] set_flag;

    assign m0 = mode_e'(timer_mode_register[`DT_M0_HI:`DT_M0_LO]); // RULE1
    assign m1 = mode_e'(timer_mode_register[`DT_M1_HI:`DT_M1_LO]);
    assign split = (m0 == MODE_SPLIT); // RULE2

    // divided clock: /12 unless the divider bit asks for fsys
    assign base[0] = timer_divider_register[`DT_FD0] | pre_tick; // RULE8
    assign base[1] = timer_divider_register[`DT_FD1] | pre_tick; // RULE8

    // timer or counter source per timer
    assign src[0] = timer_mode_register[`DT_CT0] ? pin_fall[0] : base[0]; // RULE6 RULE7
    assign src[1] = timer_mode_register[`DT_CT1] ? pin_fall[1] : base[1]; // RULE6 RULE7

    // first timer, or its low byte in split mode
    assign inc0 = timer_control_register[`DT_RUN0] & src[0]; // RULE9 RULE15
    // split high byte: divided clock only, second run bit
    assign inc0h = split & timer_control_register[`DT_RUN1] & base[0]; // RULE16
    // second timer halts on code 11 and while split borrows its run bit
    assign inc1 = timer_control_register[`DT_RUN1] & src[1] & ~split
                  & (m1 != MODE_SPLIT); // RULE2 RULE17 RULE18

    assign s0 = step(m0, first_timer_high_byte, first_timer_low_byte);
    assign s1 = step(m1, second_timer_high_byte, second_timer_low_byte); // RULE14

    assign ovf0 = inc0 & s0.ovf; // RULE4
    assign ovf0h = inc0h & (first_timer_high_byte == 8'hff); // RULE16
    assign ovf1 = inc1 & s1.ovf; // RULE5
    assign set_flag = {ovf1 | ovf0h, ovf0};

    ////////////////////////////////////////////////////////////////////
    // configuration registers

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            timer_mode_register <= `DT_RST_BYTE;
            timer_control_register <= `DT_RST_2BIT;
            timer_divider_register <= `DT_RST_2BIT;
            timer_mask <= `DT_RST_2BIT;
        end else begin
            if (wr_at(`DT_OFS_MODE)) begin
                timer_mode_register <= i_apb.pwdata[7:0] & `DT_MODE_WMASK;
            end
            if (wr_at(`DT_OFS_CTRL)) begin
                timer_control_register <= i_apb.pwdata[1:0];
            end
            if (wr_at(`DT_OFS_DIV)) begin
                timer_divider_register <= i_apb.pwdata[1:0];
            end
            if (wr_at(`DT_OFS_MASK)) begin
                timer_mask <= i_apb.pwdata[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // first timer bytes; a bus write wins over a count in the same cycle

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            first_timer_low_byte <= `DT_RST_BYTE;
            first_timer_high_byte <= `DT_RST_BYTE;
        end else begin
            if (wr_at(`DT_OFS_T0L)) begin
                first_timer_low_byte <= i_apb.pwdata[7:0];
            end else if (inc0) begin
                first_timer_low_byte <= s0.lo; // RULE13
            end
            if (wr_at(`DT_OFS_T0H)) begin
                first_timer_high_byte <= i_apb.pwdata[7:0];
            end else if (inc0h) begin
                first_timer_high_byte <= first_timer_high_byte + 8'h01; // RULE16
            end else if (inc0 && !split) begin
                first_timer_high_byte <= s0.hi; // RULE11
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // second timer bytes

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            second_timer_low_byte <= `DT_RST_BYTE;
            second_timer_high_byte <= `DT_RST_BYTE;
        end else begin
            if (wr_at(`DT_OFS_T1L)) begin
                second_timer_low_byte <= i_apb.pwdata[7:0];
            end else if (inc1) begin
                second_timer_low_byte <= s1.lo; // RULE14
            end
            if (wr_at(`DT_OFS_T1H)) begin
                second_timer_high_byte <= i_apb.pwdata[7:0];
            end else if (inc1) begin
                second_timer_high_byte <= s1.hi;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sticky flags: a read clears only the bits it reported, so an
    // overflow landing between capture and completion is kept

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            timer_status <= `DT_RST_2BIT;
        end else if (rd_stat) begin
            timer_status <= (timer_status & ~rd_data[1:0]) | set_flag; // RULE4
        end else begin
            timer_status <= timer_status | set_flag; // RULE4 RULE5
        end
    end

    // level interrupt while an unmasked flag stands
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(timer_status & timer_mask); // RULE4
        end
    end

    ////////////////////////////////////////////////////////////////////
    // apb answer: one wait state, data captured in the first access cycle

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            ready <= 1'b0;
            rd_err <= 1'b0;
            rd_data <= '0;
        end else begin
            ready <= bus_setup;
            // error stands only beside pready, so pslverr comes straight off a flop
            rd_err <= bus_setup & ~known_addr(i_apb.paddr);
            if (bus_setup) begin
                rd_data <= '0;
                if (!i_apb.pwrite) begin
                    case (i_apb.paddr)
                        `DT_OFS_MODE: rd_data[7:0] <= timer_mode_register;
                        `DT_OFS_CTRL: rd_data[1:0] <= timer_control_register;
                        `DT_OFS_DIV: rd_data[1:0] <= timer_divider_register;
                        `DT_OFS_T0L: rd_data[7:0] <= first_timer_low_byte;
                        `DT_OFS_T0H: rd_data[7:0] <= first_timer_high_byte;
                        `DT_OFS_T1L: rd_data[7:0] <= second_timer_low_byte;
                        `DT_OFS_T1H: rd_data[7:0] <= second_timer_high_byte;
                        `DT_OFS_STAT: rd_data[1:0] <= timer_status;
                        `DT_OFS_MASK: rd_data[1:0] <= timer_mask;
                        default: rd_data <= '0;
                    endcase
                end
            end
        end
    end

    // every field of the answer is a register
    assign o_apb = '{pready: ready, pslverr: rd_err, prdata: rd_data};
    assign o_irq = irq;

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_nrst);

    sequence s_access;
        i_apb.psel && i_apb.penable && !ready;
    endsequence
    sequence s_answer;
        ready ##1 !ready;
    endsequence

    a_apb_one_wait: assert property (s_access |=> s_answer)
        else $error("apb answer not after one wait");

    a_prescale_period: assert property (pre_tick |-> ##12 pre_tick) // RULE8
        else $error("prescaler period is not 12");
    a_prescale_gap: assert property (pre_tick |=> !pre_tick [*8]) // RULE8
        else $error("prescaler ticks too often");

    a_pin_one_pulse: assert property (pin_fall[0] |=> !pin_fall[0]) // RULE19
        else $error("one edge counted twice");

    a_run_holds: assert property (!timer_control_register[`DT_RUN0] && !wr_now // RULE9
        |=> $stable(first_timer_low_byte))
        else $error("first timer moved while stopped");

    a_split_stops: assert property (split && !wr_now // RULE17
        |=> $stable({second_timer_high_byte, second_timer_low_byte}))
        else $error("second timer counted in split mode");

    a_reload_copy: assert property (m0 == MODE_RELOAD8 && inc0 && !wr_now // RULE13
        && first_timer_low_byte == 8'hff
        |=> first_timer_low_byte == $past(first_timer_high_byte)
        && timer_status[`DT_OVF0])
        else $error("reload or flag missing on wrap");

    a_wrap_13bit: assert property (m0 == MODE_13BIT && inc0 && !wr_now // RULE3
        && first_timer_high_byte == 8'hff && first_timer_low_byte[4:0] == 5'h1f
        |=> first_timer_high_byte == 8'h00 && first_timer_low_byte[4:0] == 5'h00
        && timer_status[`DT_OVF0])
        else $error("13-bit wrap wrong");

    a_split_high_flag: assert property (ovf0h |=> timer_status[`DT_OVF1]) // RULE16
        else $error("split high overflow lost");

    a_irq_follows: assert property (timer_status[`DT_OVF1] && timer_mask[`DT_OVF1] // RULE5
        |=> irq)
        else $error("interrupt not raised");

endmodule
`default_nettype wire
